// ==== hw/b_side_input_range_regs.v ====
// Purpose: b-side channel input range registers behind an axi4-lite slave
// Assumes: one clock, synchronous active-high reset
// Notes: each 16-bit register sits in the low half of an aligned word
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "b_range_regs.vh"
module b_side_input_range_regs (
   // clock and reset
   input wire mclk,
   input wire sys_rst,
   // write address channel
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // write data channel
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // write response channel
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // read address channel
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // read data channel
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // raw range codes, two bits per channel
   output reg [1:0] b_input_zero_ff,
   output reg [1:0] b_input_one_ff,
   output reg [1:0] b_input_two_ff,
   output reg [1:0] b_input_three_ff,
   output reg [1:0] b_input_four_ff,
   output reg [1:0] b_input_five_ff,
   output reg [1:0] b_input_six_ff,
   output reg [1:0] b_input_seven_ff,
   // one-hot range selects {10v,5v,2v5}, channel n at [3n+2:3n]
   output wire [23:0] rangeSel
);
   reg [15:0] lowReg_ff;
   reg [15:0] highReg_ff;
   reg [7:0] awAddr_ff;
   reg awHave_ff;
   reg [31:0] wData_ff;
   reg [3:0] wStrb_ff;
   reg wHave_ff;
   reg [15:0] nxt_lowReg;
   reg [15:0] nxt_highReg;
   reg wrOk;
   wire doWrite;
   wire doRead;
   wire doResp;
   wire [15:0] lowNext;
   wire [15:0] highNext;
   wire [1:0] wrHit;
   wire [1:0] rdHit;
   wire [32:0] rdLook;

   // byte-lane merge; reserved bit always kept zero
   function [15:0] merge;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      reg [15:0] tmp;
      begin
         tmp = old;
         if (strb[0]) tmp[`BYTE_LANE0] = data[`BYTE_LANE0];
         if (strb[1]) tmp[`BYTE_LANE1] = data[`BYTE_LANE1];
         tmp[`RSVD_BIT] = 1'b0;
         merge = tmp;
      end
   endfunction

   // word decode: bit 0 hits the low register, bit 1 the high one
   function [1:0] regHit;
      input [7:0] addr;
      reg [7:0] aligned;
      begin
         aligned = addr & `WORD_MASK;
         case (aligned)
            `ADDR_B_LOW: regHit = `HIT_LOW;
            `ADDR_B_HIGH: regHit = `HIT_HIGH;
            default: regHit = `HIT_NONE;
         endcase
      end
   endfunction

   // read value for a decoded hit; bit 32 flags a hit
   function [32:0] lookup;
      input [1:0] hit;
      input [15:0] lowV;
      input [15:0] highV;
      begin
         case (hit)
            `HIT_LOW: lookup = {1'b1, `PAD_ZERO, lowV};
            `HIT_HIGH: lookup = {1'b1, `PAD_ZERO, highV};
            default: lookup = {1'b0, `WORD_RESET};
         endcase
      end
   endfunction

   assign wrHit = regHit(awAddr_ff);
   assign rdHit = regHit(s_axi_araddr);
   assign rdLook = lookup(rdHit, lowReg_ff, highReg_ff);
   assign doWrite = awHave_ff & wHave_ff & ~s_axi_bvalid;
   assign doResp = s_axi_bvalid & s_axi_bready;
   assign doRead = s_axi_arvalid & s_axi_arready;
   assign lowNext = merge(lowReg_ff, wData_ff, wStrb_ff);
   assign highNext = merge(highReg_ff, wData_ff, wStrb_ff);

   always @* begin
      nxt_lowReg = lowReg_ff;
      nxt_highReg = highReg_ff;
      wrOk = 1'b0;
      if (doWrite) begin
         case (wrHit)
            `HIT_LOW: begin
               nxt_lowReg = lowNext;
               wrOk = 1'b1;
            end
            `HIT_HIGH: begin
               nxt_highReg = highNext;
               wrOk = 1'b1;
            end
            default: wrOk = 1'b0;
         endcase
      end
   end

   // write address slot, held until the response is taken
   always @(posedge mclk) begin
      if (sys_rst) begin
         awHave_ff <= 1'b0;
         awAddr_ff <= `ADDR_RESET;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= ~awHave_ff & ~s_axi_awready & s_axi_awvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end else if (doResp) begin
            awHave_ff <= 1'b0;
         end
      end
   end

   // write data slot, filled independently of the address
   always @(posedge mclk) begin
      if (sys_rst) begin
         wHave_ff <= 1'b0;
         wData_ff <= `WORD_RESET;
         wStrb_ff <= `STRB_RESET;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= ~wHave_ff & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_wvalid & s_axi_wready) begin
            wHave_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end else if (doResp) begin
            wHave_ff <= 1'b0;
         end
      end
   end

   // write response: raised once both slots hold, dropped when taken
   always @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end else if (doResp) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register storage
   always @(posedge mclk) begin
      if (sys_rst) begin
         lowReg_ff <= `RANGE_RESET;
         highReg_ff <= `RANGE_RESET;
      end else begin
         lowReg_ff <= nxt_lowReg;
         highReg_ff <= nxt_highReg;
      end
   end

   // range code outputs, updated at the same edge as storage
   always @(posedge mclk) begin
      if (sys_rst) begin
         b_input_zero_ff <= `CODE_10V_B;
         b_input_one_ff <= `CODE_10V_B;
         b_input_two_ff <= `CODE_10V_B;
         b_input_three_ff <= `CODE_10V_B;
         b_input_four_ff <= `CODE_10V_B;
         b_input_five_ff <= `CODE_10V_B;
         b_input_six_ff <= `CODE_10V_B;
         b_input_seven_ff <= `CODE_10V_B;
      end else begin
         b_input_zero_ff <= nxt_lowReg[`FLD_LANE0];
         b_input_one_ff <= nxt_lowReg[`FLD_LANE1];
         b_input_two_ff <= nxt_lowReg[`FLD_LANE2];
         b_input_three_ff <= nxt_lowReg[`FLD_LANE3];
         b_input_four_ff <= nxt_highReg[`FLD_LANE0];
         b_input_five_ff <= nxt_highReg[`FLD_LANE1];
         b_input_six_ff <= nxt_highReg[`FLD_LANE2];
         b_input_seven_ff <= nxt_highReg[`FLD_LANE3];
      end
   end

   // read address: ready withheld while a read answer still waits
   always @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      end
   end

   // read data: answer two edges after arvalid, held until rready
   always @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `WORD_RESET;
         s_axi_rresp <= `RESP_OKAY;
      end else if (doRead) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdLook[`LOOK_DATA];
         s_axi_rresp <= rdLook[`LOOK_HIT] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // one-hot range selects, driven from registered codes
   range_decode dec0 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_zero_ff),
      .rangeSel_ff(rangeSel[2:0])
   );

   range_decode dec1 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_one_ff),
      .rangeSel_ff(rangeSel[5:3])
   );

   range_decode dec2 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_two_ff),
      .rangeSel_ff(rangeSel[8:6])
   );

   range_decode dec3 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_three_ff),
      .rangeSel_ff(rangeSel[11:9])
   );

   range_decode dec4 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_four_ff),
      .rangeSel_ff(rangeSel[14:12])
   );

   range_decode dec5 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_five_ff),
      .rangeSel_ff(rangeSel[17:15])
   );

   range_decode dec6 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_six_ff),
      .rangeSel_ff(rangeSel[20:18])
   );

   range_decode dec7 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .code(b_input_seven_ff),
      .rangeSel_ff(rangeSel[23:21])
   );
endmodule

// ==== hw/b_range_regs.vh ====
// Purpose: constants for the b-side input range register bank
// Assumes: included by the design files by bare name
// Notes: byte address is four times the register index
`ifndef B_RANGE_REGS_VH
`define B_RANGE_REGS_VH
`define IDX_B_LOW 8'h06
`define IDX_B_HIGH 8'h07
`define ADDR_B_LOW 8'h18
`define ADDR_B_HIGH 8'h1c
`define RANGE_RESET 16'h00ff
`define ADDR_FIELD_HI 15
`define ADDR_FIELD_LO 9
`define RSVD_BIT 8
`define CODE_10V_A 2'h0
`define CODE_2V5 2'h1
`define CODE_5V 2'h2
`define CODE_10V_B 2'h3
`define SEL_10V 3'h4
`define SEL_5V 3'h2
`define SEL_2V5 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_MASK 8'hfc
`define HIT_NONE 2'h0
`define HIT_LOW 2'h1
`define HIT_HIGH 2'h2
`define LOOK_HIT 32
`define LOOK_DATA 31:0
`define PAD_ZERO 16'h0000
`define WORD_RESET 32'h00000000
`define ADDR_RESET 8'h00
`define STRB_RESET 4'h0
`define BYTE_LANE0 7:0
`define BYTE_LANE1 15:8
`define FLD_LANE0 1:0
`define FLD_LANE1 3:2
`define FLD_LANE2 5:4
`define FLD_LANE3 7:6
`endif

// ==== hw/range_decode.v ====
// Purpose: turns one two-bit range code into a one-hot range select
// Assumes: code is a registered value from the range bank
// Notes: output is registered
`timescale 1ns/10ps
`include "b_range_regs.vh"
module range_decode (
   // clock and reset
   input wire mclk,
   input wire sys_rst,
   // code in, one-hot select out {10v,5v,2v5}
   input wire [1:0] code,
   output reg [2:0] rangeSel_ff
);
   reg [2:0] nxt_rangeSel;
   always @* begin
      case (code)
         `CODE_2V5: nxt_rangeSel = `SEL_2V5;
         `CODE_5V: nxt_rangeSel = `SEL_5V;
         `CODE_10V_A: nxt_rangeSel = `SEL_10V;
         default: nxt_rangeSel = `SEL_10V;
      endcase
   end
   always @(posedge mclk) begin
      if (sys_rst) begin
         rangeSel_ff <= `SEL_10V;
      end else begin
         rangeSel_ff <= nxt_rangeSel;
      end
   end
endmodule

// ==== verification/b_range_chk.sv ====
// Purpose: port checks on the range bank
// Assumes: bound to b_side_input_range_regs
// Notes: channels zero and four stand for their registers
`timescale 1ns/10ps
module b_range_chk (
   // clock and reset
   input wire mclk,
   input wire sys_rst,
   // bus
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // range outputs
   input wire [1:0] b_input_zero_ff,
   input wire [1:0] b_input_four_ff,
   input wire [23:0] rangeSel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_RST_CODE: assert property (disable iff (1'b0) sys_rst |=>
      b_input_zero_ff == 2'h3 && b_input_four_ff == 2'h3)
      else $error("code not 11 after reset");
   AST_RST_SEL: assert property (disable iff (1'b0) sys_rst[*2] |=>
      rangeSel == 24'h924924) else $error("select not 10 V after reset");
   AST_DEC_25: assert property (b_input_zero_ff == 2'h1 |=>
      rangeSel[2:0] == 3'h1) else $error("code 01 not 2.5 V");
   AST_DEC_5: assert property (b_input_four_ff == 2'h2 |=>
      rangeSel[14:12] == 3'h2) else $error("code 10 not 5 V");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write answer not held");
   AST_RD_RSVD: assert property (s_axi_rvalid |->
      s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[8])
      else $error("reserved read bits set");
endmodule

// ==== verification/range_host.sv ====
// Purpose: axi4-lite host model for the range bank
// Assumes: one write and one read at a time
// Notes: slow holds bready and rready off until the answer shows
`timescale 1ns/10ps
module range_host (
   // clock and pacing
   input wire mclk,
   input wire slow,
   // write side
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} <= '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} <= '0;
      s_axi_rready <= 1'b0;
   end
   // callers keep bit 8 clear save two rows, one of which has lane 1 strobed off
   task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the range bank
// Assumes: host model drives the register bus
// Notes: rows hold address, data, strobes, response, readback
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [1:0] r;
      logic [31:0] q;
   } row_t;
   row_t rows [5] = '{
      '{8'h18, 32'h0000a6e1, 4'hf, 2'h0, 32'h0000a6e1},
      '{8'h1c, 32'h00000e1e, 4'hf, 2'h0, 32'h00000e1e},
      '{8'h18, 32'hffff03ff, 4'h3, 2'h0, 32'h000002ff},
      '{8'h1c, 32'h0000ff00, 4'h1, 2'h0, 32'h00000e00},
      '{8'h20, 32'h12345678, 4'hf, 2'h2, 32'h00000000}};
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic slow = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   logic [15:0] lo;
   logic [15:0] hi;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   wire s_axi_rvalid, s_axi_rready;
   wire [23:0] rangeSel;
   wire [15:0] codes;
   range_host range_host_inst (.*);
   b_side_input_range_regs b_side_input_range_regs_inst (.*,
      .b_input_zero_ff(codes[1:0]), .b_input_one_ff(codes[3:2]),
      .b_input_two_ff(codes[5:4]), .b_input_three_ff(codes[7:6]),
      .b_input_four_ff(codes[9:8]), .b_input_five_ff(codes[11:10]),
      .b_input_six_ff(codes[13:12]), .b_input_seven_ff(codes[15:14]));
   always #5 mclk = ~mclk;
   task check(input [31:0] seen, input [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function [23:0] sel(input [15:0] c);
      for (int k = 0; k < 8; k++)
         sel[3*k+:3] = c[2*k+:2] == 2'h1 ? 3'h1 :
            c[2*k+:2] == 2'h2 ? 3'h2 : 3'h4;
   endfunction
   task look;
      logic [31:0] d;
      logic [1:0] r;
      range_host_inst.rd(8'h18, d, r);
      check(d, {16'h0, lo});
      range_host_inst.rd(8'h1c, d, r);
      check(d, {16'h0, hi});
      check(codes, {hi[7:0], lo[7:0]});
      check(rangeSel, sel({hi[7:0], lo[7:0]}));
   endtask
   task do_reset;
      sys_rst <= 1'b1;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      lo = 16'h00ff;
      hi = 16'h00ff;
      look;
      $display("test reset done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      do_reset;
      foreach (rows[i]) begin
         slow <= i[0];
         range_host_inst.wr(rows[i].a, rows[i].d, rows[i].s, r);
         check(r, rows[i].r);
         range_host_inst.rd(rows[i].a, d, r);
         check(r, rows[i].r);
         check(d, rows[i].q);
         if (rows[i].a == 8'h18) lo = rows[i].q[15:0];
         if (rows[i].a == 8'h1c) hi = rows[i].q[15:0];
         look;
         $display("test %0d done", i);
      end
      do_reset;
      summarize;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      bad_count++;
      summarize;
   end
endmodule
bind b_side_input_range_regs b_range_chk b_range_chk_inst (.*);
